// *** aabs_cpu.sv ***
// apb master standing in for the processor that reads the alarm registers
`timescale 1ns/1ps
module aabs_cpu (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end

  // one transfer; only the bench watchdog ends the wait for pready
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// *** aabs_pkg.sv ***
// shared constants and types for the add bus clock alarm status block
package aabs_pkg;

  // ************************************************
  // register indices (byte address is four times index)
  // ************************************************
  localparam logic [7:0] IDX_LATCHED = 8'h52;
  localparam logic [7:0] IDX_ONE_SEC = 8'h53;
  localparam logic [7:0] IDX_PERSIST = 8'h54;
  localparam logic [7:0] IDX_POLLING = 8'h55;
  localparam logic [7:0] IDX_RSVD_A = 8'h56;
  localparam logic [7:0] IDX_RSVD_B = 8'h57;
  localparam logic [7:0] IDX_RSVD_C = 8'h58;
  localparam logic [7:0] IDX_RST_DONE = 8'h59;
  localparam logic [7:0] IDX_CTRL = 8'h5a;
  localparam logic [7:0] IDX_POLL_MASK = 8'h5b;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h5c;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h5d;

  // ************************************************
  // field positions and reset values
  // ************************************************
  localparam int BIT_A = 0;
  localparam int BIT_B = 1;
  localparam int IRQ_A_LATCHED = 0;
  localparam int IRQ_B_LATCHED = 1;
  localparam int IRQ_POLLING = 2;
  localparam int IRQ_RST_DONE = 3;
  localparam int IRQ_W = 4;
  localparam logic [7:0] CTRL_RESET = 8'h02;
  localparam logic [7:0] POLL_MASK_RESET = 8'h00;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

  // edge select codes
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // ************************************************
  // timing
  // ************************************************
  localparam int CLK_MHZ = 10;
  localparam int LOC_CYCLES = 56;
  localparam int RST_DONE_NS = 4000;
  localparam int RST_DONE_CYCLES = (RST_DONE_NS * CLK_MHZ + 999) / 1000;
  localparam int ONE_SEC_TIMEOUT_CYCLES = 2 * CLK_MHZ * 1000000;

  // control register layout
  typedef struct packed {
    logic [3:0] unused;
    logic soft_reset;
    logic [1:0] edge_sel;
    logic add_timing_mode;
  } aabs_ctrl_t;

endpackage

// *** aabs_status.sv ***
// add bus clock loss alarm status registers with apb slave
`timescale 1ns/1ps
module aabs_status
  import aabs_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int ONE_SEC_TIMEOUT = ONE_SEC_TIMEOUT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic a_add_clk,
  input wire logic b_add_clk,
  input wire logic one_sec_pulse,
  input wire logic [7:0] chan_add_alarm,
  input wire logic [7:0] chan_add_read,
  output logic irq,
  output logic [1:0] add_clk_loss_live,
  output logic reset_completed
);

  if (ADDR_W < 10) begin : g_addr_check
    $error("ADDR_W too small for register map");
  end
  if (ONE_SEC_TIMEOUT < 2) begin : g_timeout_check
    $error("ONE_SEC_TIMEOUT too small");
  end

  function automatic logic edge_hit(input logic [1:0] sel, input logic now,
                                    input logic was);
    logic rise;
    logic fall;
    rise = now & ~was;
    fall = ~now & was;
    edge_hit = (sel[0] & rise) | (sel[1] & fall);
  endfunction

  function automatic logic idx_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [7:0] idx);
    idx_hit = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] == (ADDR_W-2)'(idx));
  endfunction

  // ************************************************
  // apb decode
  // ************************************************
  aabs_ctrl_t ctrl;
  logic [7:0] poll_mask;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [1:0] latched;
  logic [1:0] one_sec;
  logic [1:0] persist;
  logic [7:0] polling;
  logic rst_done;

  wire access = psel & penable & ~pready;
  wire done = psel & penable & pready;
  wire wr_done = done & pwrite & pstrb[0];
  wire rd_done = done & ~pwrite;
  wire hit_latched = idx_hit(paddr, IDX_LATCHED);
  wire hit_one_sec = idx_hit(paddr, IDX_ONE_SEC);
  wire hit_persist = idx_hit(paddr, IDX_PERSIST);
  wire hit_polling = idx_hit(paddr, IDX_POLLING);
  wire hit_rst = idx_hit(paddr, IDX_RST_DONE);
  wire hit_ctrl = idx_hit(paddr, IDX_CTRL);
  wire hit_pmask = idx_hit(paddr, IDX_POLL_MASK);
  wire hit_istat = idx_hit(paddr, IDX_IRQ_STATUS);
  wire hit_imask = idx_hit(paddr, IDX_IRQ_MASK);
  wire wr_ctrl = wr_done & hit_ctrl;
  wire wr_pmask = wr_done & hit_pmask;
  wire wr_istat = wr_done & hit_istat;
  wire wr_imask = wr_done & hit_imask;
  wire rd_latched = rd_done & hit_latched;

  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (hit_latched) begin
      rd_mux = {6'h00, latched};
    end else if (hit_one_sec) begin
      rd_mux = {6'h00, one_sec};
    end else if (hit_persist) begin
      rd_mux = {6'h00, persist};
    end else if (hit_polling) begin
      rd_mux = polling;
    end else if (hit_rst) begin
      rd_mux = {7'h00, rst_done};
    end else if (hit_ctrl) begin
      rd_mux = {4'h0, 1'b0, ctrl.edge_sel, ctrl.add_timing_mode};
    end else if (hit_pmask) begin
      rd_mux = poll_mask;
    end else if (hit_istat) begin
      rd_mux = {4'h0, irq_status};
    end else if (hit_imask) begin
      rd_mux = {4'h0, irq_mask};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= access;
      pslverr <= 1'b0;
      // read data is taken on the first access cycle and holds until the next read
      if (access && !pwrite) begin
        prdata <= {24'h00_0000, rd_mux};
      end
    end
  end

  // ************************************************
  // control registers and software reset
  // ************************************************
  wire soft_rst = wr_ctrl & pwdata[3];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= aabs_ctrl_t'(CTRL_RESET);
      poll_mask <= POLL_MASK_RESET;
      irq_mask <= IRQ_MASK_RESET;
    end else if (ce) begin
      if (wr_ctrl) begin
        // bit 3 only fires the software reset and is never stored
        ctrl <= aabs_ctrl_t'({5'h00, pwdata[2:0]});
      end
      if (wr_pmask) begin
        poll_mask <= pwdata[7:0];
      end
      if (wr_imask) begin
        irq_mask <= pwdata[IRQ_W-1:0];
      end
    end
  end
  // ************************************************
  // reset completion timer
  // ************************************************
  localparam int RW = $clog2(RST_DONE_CYCLES + 1);
  logic [RW-1:0] rst_cnt;
  wire rst_cnt_end = (rst_cnt == RW'(RST_DONE_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt <= '0;
      rst_done <= 1'b0;
    end else if (ce) begin
      if (soft_rst) begin
        rst_cnt <= '0;
        rst_done <= 1'b0;
      end else if (!rst_done) begin
        rst_cnt <= rst_cnt + RW'(1);
        if (rst_cnt_end) begin
          rst_done <= 1'b1;
        end
      end
    end
  end
  // ************************************************
  // pin synchronisers
  // ************************************************
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] pin_prev;
  wire [2:0] pins = {one_sec_pulse, b_add_clk, a_add_clk};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      pin_prev <= 3'h0;
    end else if (ce) begin
      sync1 <= pins;
      sync2 <= sync1;
      pin_prev <= sync2;
    end
  end

  wire [1:0] clk_toggle = sync2[1:0] ^ pin_prev[1:0];
  wire sec_tick = sync2[2] & ~pin_prev[2];

  // ************************************************
  // loss of clock detectors
  // ************************************************
  localparam int LW = $clog2(LOC_CYCLES + 1);
  logic [LW-1:0] stuck_cnt [2];
  logic [1:0] live;
  logic [1:0] live_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stuck_cnt[0] <= '0;
      stuck_cnt[1] <= '0;
      live <= 2'h0;
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        if (clk_toggle[i] || soft_rst) begin
          stuck_cnt[i] <= '0;
          live[i] <= 1'b0;
        end else if (stuck_cnt[i] != LW'(LOC_CYCLES)) begin
          stuck_cnt[i] <= stuck_cnt[i] + LW'(1);
          live[i] <= 1'b0;
        end else begin
          live[i] <= ctrl.add_timing_mode;
        end
      end
    end
  end

  // ************************************************
  // latched alarms
  // ************************************************
  // a read clears only the bits it returned, so an alarm landing mid-read is kept
  wire [1:0] lat_clr = rd_latched ? prdata[1:0] : 2'h0;
  logic [1:0] lat_set;
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      lat_set[i] = ctrl.add_timing_mode & edge_hit(ctrl.edge_sel, live[i],
                                                   live_prev[i]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live_prev <= 2'h0;
      latched <= 2'h0;
    end else if (ce) begin
      live_prev <= live;
      if (soft_rst) begin
        latched <= 2'h0;
      end else begin
        latched <= lat_set | (latched & ~lat_clr);
      end
    end
  end

  // ************************************************
  // one-second and persistent indications
  // ************************************************
  localparam int WW = $clog2(ONE_SEC_TIMEOUT + 1);
  logic [WW-1:0] wd_cnt;
  logic sec_present;
  logic [1:0] changed;
  logic [1:0] rose;
  wire [1:0] live_chg = live ^ live_prev;
  wire [1:0] live_rise = live & ~live_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cnt <= '0;
      sec_present <= 1'b0;
    end else if (ce) begin
      if (sec_tick) begin
        wd_cnt <= '0;
        sec_present <= 1'b1;
      end else if (wd_cnt == WW'(ONE_SEC_TIMEOUT - 1)) begin
        sec_present <= 1'b0;
      end else begin
        wd_cnt <= wd_cnt + WW'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      changed <= 2'h0;
      rose <= 2'h0;
      one_sec <= 2'h0;
      persist <= 2'h0;
    end else if (ce) begin
      if (soft_rst || !sec_present) begin
        changed <= 2'h0;
        rose <= 2'h0;
        one_sec <= 2'h0;
        persist <= 2'h0;
      end else if (sec_tick) begin
        one_sec <= changed | live_chg | live;
        persist <= live & ~rose & ~live_rise;
        changed <= 2'h0;
        rose <= 2'h0;
      end else begin
        changed <= changed | live_chg;
        rose <= rose | live_rise;
      end
    end
  end

  // ************************************************
  // channel polling register
  // ************************************************
  wire [7:0] poll_set = chan_add_alarm & poll_mask;
  wire [7:0] poll_mask_clr = wr_pmask ? ~pwdata[7:0] : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      polling <= 8'h00;
    end else if (ce) begin
      if (soft_rst) begin
        polling <= 8'h00;
      end else begin
        polling <= poll_set | (polling & ~chan_add_read & ~poll_mask_clr);
      end
    end
  end

  // ************************************************
  // interrupt status, mask and output
  // ************************************************
  logic [IRQ_W-1:0] irq_event;
  always_comb begin
    irq_event = '0;
    irq_event[IRQ_A_LATCHED] = lat_set[BIT_A];
    irq_event[IRQ_B_LATCHED] = lat_set[BIT_B];
    irq_event[IRQ_POLLING] = |poll_set;
    irq_event[IRQ_RST_DONE] = rst_cnt_end & ~rst_done & ~soft_rst;
  end

  wire [IRQ_W-1:0] irq_clr = wr_istat ? pwdata[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] next_irq_status = irq_event | (irq_status & ~irq_clr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      irq_status <= next_irq_status;
      irq <= |(next_irq_status & irq_mask);
    end
  end

  // ************************************************
  // status outputs
  // ************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      add_clk_loss_live <= 2'h0;
      reset_completed <= 1'b0;
    end else if (ce) begin
      add_clk_loss_live <= live;
      reset_completed <= rst_done;
    end
  end

endmodule

// *** aabs_status_asserts.sv ***
// concurrent checks on the ports of the add bus clock alarm status block
`timescale 1ns/1ps
module aabs_status_asserts
  import aabs_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic a_add_clk,
  input wire logic [1:0] add_clk_loss_live,
  input wire logic reset_completed
);
  // ****
  // helper counters
  // ****
  logic [7:0] since_rst;
  logic [7:0] a_still;
  logic a_prev;
  wire soft_wr = psel && penable && pready && pwrite && pstrb[0] && pwdata[3]
    && paddr == ADDR_W'({IDX_CTRL, 2'h0});
  wire [7:0] next_a_still = (a_add_clk != a_prev) ? 8'h0 : a_still + {7'h0, a_still != 8'hff};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_rst <= 8'h0;
    end else if (soft_wr) begin
      since_rst <= 8'h0;
    end else if (since_rst != 8'hff) begin
      since_rst <= since_rst + 8'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_prev <= 1'b0;
      a_still <= 8'h0;
    end else begin
      a_prev <= a_add_clk;
      a_still <= next_a_still;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence apb_wait;
    psel && penable && !pready;
  endsequence
  sequence soft_done;
    soft_wr;
  endsequence

  chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_pready_wait: assert property (apb_wait |=> pready)
    else $error("pready late");
  chk_pready_once: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_no_slverr: assert property (pready |-> !pslverr)
    else $error("slave error raised");
  chk_loss_rise: assert property ($rose(add_clk_loss_live[0]) |-> a_still >= 8'h37)
    else $error("loss alarm raised too early");
  chk_loss_clear: assert property (add_clk_loss_live[0] && a_still == 8'h0
    |-> ##[1:6] !add_clk_loss_live[0])
    else $error("loss alarm not cleared on clock edge");
  chk_done_early: assert property (reset_completed |-> since_rst == 8'h0 || since_rst >= 8'h28)
    else $error("reset completed too early");
  chk_done_late: assert property (since_rst == 8'h32 |-> reset_completed)
    else $error("reset completed too late");
  chk_soft_clear: assert property (soft_done |=> ##1 !reset_completed)
    else $error("reset completed not dropped");
endmodule

bind aabs_status aabs_status_asserts #(.ADDR_W(ADDR_W)) u_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .a_add_clk(a_add_clk), .add_clk_loss_live(add_clk_loss_live),
  .reset_completed(reset_completed)
);

// *** aabs_status_bench.sv ***
// self-checking bench for the add bus clock alarm status block
`timescale 1ns/1ps
module aabs_status_bench;
  import aabs_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq, reset_completed;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [1:0] live;
  logic run_a = 1'b1;
  logic run_b = 1'b1;
  logic a_add_clk = 1'b0;
  logic b_add_clk = 1'b0;
  logic one_sec_pulse = 1'b0;
  logic [7:0] chan_add_alarm = 8'h0;
  logic [7:0] chan_add_read = 8'h0;
  logic [7:0] rsv [4] = '{IDX_RSVD_A, IDX_RSVD_B, IDX_RSVD_C, 8'h7f};
  int num_errors = 0;
  int tests_run = 0;

  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    a_add_clk <= a_add_clk ^ run_a;
    b_add_clk <= b_add_clk ^ run_b;
  end

  aabs_cpu cpu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready));

  aabs_status #(.ONE_SEC_TIMEOUT(200)) uut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .a_add_clk(a_add_clk), .b_add_clk(b_add_clk), .one_sec_pulse(one_sec_pulse),
    .chan_add_alarm(chan_add_alarm), .chan_add_read(chan_add_read), .irq(irq),
    .add_clk_loss_live(live), .reset_completed(reset_completed));

  // ****
  // access and compare tasks
  // ****
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    cpu.xfer(1'b1, idx, d, q);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    cpu.xfer(1'b0, idx, 8'h0, q);
    chk(q, exp);
  endtask
  task automatic pulse();
    one_sec_pulse <= 1'b1;
    cyc(3);
    one_sec_pulse <= 1'b0;
    cyc(6);
  endtask
  task automatic test_done();
    if (num_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    cyc(6000);
    num_errors++;
    test_done();
  end

  initial begin
    int i;
    cyc(5);
    presetn <= 1'b1;
    cyc(1);
    #1 chk({7'h0, reset_completed}, 8'h00);
    while (reset_completed !== 1'b1) cyc(1);
    rd(IDX_RST_DONE, 8'h01);
    wr(IDX_CTRL, 8'h03);
    run_a <= 1'b0;
    cyc(70);
    #1 chk({6'h0, live}, 8'h01);
    rd(IDX_LATCHED, 8'h01);
    rd(IDX_LATCHED, 8'h00);
    run_a <= 1'b1;
    cyc(8);
    #1 chk({6'h0, live}, 8'h00);
    for (i = 1; i < 4; i++) begin
      wr(IDX_CTRL, {5'h0, i[1:0], 1'b1});
      rd(IDX_LATCHED, 8'h00);
      run_b <= 1'b0;
      cyc(70);
      rd(IDX_LATCHED, i[0] ? 8'h02 : 8'h00);
      run_b <= 1'b1;
      cyc(8);
      rd(IDX_LATCHED, i[1] ? 8'h02 : 8'h00);
    end
    wr(IDX_CTRL, 8'h02);
    run_b <= 1'b0;
    cyc(70);
    #1 chk({6'h0, live}, 8'h00);
    rd(IDX_LATCHED, 8'h00);
    run_b <= 1'b1;
    rd(IDX_ONE_SEC, 8'h00);
    wr(IDX_CTRL, 8'h03);
    pulse();
    run_a <= 1'b0;
    cyc(70);
    pulse();
    rd(IDX_ONE_SEC, 8'h01);
    rd(IDX_PERSIST, 8'h00);
    pulse();
    rd(IDX_ONE_SEC, 8'h01);
    rd(IDX_PERSIST, 8'h01);
    run_a <= 1'b1;
    cyc(8);
    pulse();
    rd(IDX_ONE_SEC, 8'h01);
    rd(IDX_PERSIST, 8'h00);
    cyc(250);
    rd(IDX_ONE_SEC, 8'h00);
    rd(IDX_PERSIST, 8'h00);
    wr(IDX_POLL_MASK, 8'h81);
    chan_add_alarm <= 8'hff;
    cyc(1);
    chan_add_alarm <= 8'h00;
    rd(IDX_POLLING, 8'h81);
    chan_add_read <= 8'h01;
    cyc(1);
    chan_add_read <= 8'h00;
    rd(IDX_POLLING, 8'h80);
    wr(IDX_POLL_MASK, 8'h01);
    rd(IDX_POLLING, 8'h00);
    #1 chk({7'h0, irq}, 8'h00);
    wr(IDX_IRQ_MASK, 8'h04);
    cyc(2);
    #1 chk({7'h0, irq}, 8'h01);
    wr(IDX_IRQ_STATUS, 8'h04);
    cyc(2);
    #1 chk({7'h0, irq}, 8'h00);
    wr(IDX_IRQ_MASK, 8'h0f);
    rd(IDX_IRQ_STATUS, 8'h0b);
    // hold A in alarm so the one-second bit is set while all irq sources are unmasked
    run_a <= 1'b0;
    cyc(70);
    wr(IDX_IRQ_STATUS, 8'hff);
    pulse();
    pulse();
    rd(IDX_ONE_SEC, 8'h01);
    run_a <= 1'b1;
    #1 chk({7'h0, irq}, 8'h00);
    for (i = 0; i < 4; i++) begin
      wr(rsv[i], 8'hff);
      rd(rsv[i], 8'h00);
    end
    wr(IDX_CTRL, 8'h09);
    cyc(1);
    #1 chk({7'h0, reset_completed}, 8'h00);
    rd(IDX_RST_DONE, 8'h00);
    cyc(45);
    rd(IDX_RST_DONE, 8'h01);
    test_done();
  end
endmodule
